// >>> logic/serial_fram_write_enable_decode.sv
`timescale 1ns/1ps
`default_nettype none
module serial_fram_write_enable_decode
   import wel_decode_pkg::*;
#(
   parameter int ADDR_W = ARRAY_ADDR_W,
   parameter int DEPTH  = ARRAY_DEPTH
) (
   // system clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // spi link, mode 0
   input  wire logic              sck,
   input  wire logic              cs_b,
   input  wire logic              si,
   output logic                   so,
   output logic                   so_oe,
   // state seen on the system side
   output logic                   write_enable_latch,
   output logic                   block_protect_lo,
   output logic                   block_protect_hi,
   output logic [ADDR_W-1:0]      last_write_addr
);
   if (ADDR_W != 9 || DEPTH != (1 << ADDR_W)) begin : g_bad_geometry
      $error("unsupported array geometry");
   end

   // ----------------------------------------
   // link domain: shift and decode
   // ----------------------------------------
   logic [7:0]        shift_in;
   logic [2:0]        bit_cnt;
   link_state_t       state;
   logic [7:0]        opcode;
   logic [ADDR_W-1:0] addr;
   logic              wel_snap;
   logic [1:0]        bp_snap;
   logic              wrote_any;
   logic              sr_written;
   logic [1:0]        sr_bp_new;
   logic [7:0]        out_shift;
   logic [7:0]        mem [0:DEPTH-1];
   logic              sr_tog;
   logic              set_tog;
   logic              clr_tog;
   logic              wr_tog;

   // the system side latch state copied into the link domain
   logic              wel_link;
   logic [1:0]        bp_link;

   wire [7:0] byte_in       = {shift_in[6:0], si};
   wire       byte_done     = (bit_cnt == 3'd7);
   wire [7:0] op_masked     = byte_in & OP_RW_MASK;
   wire       is_mem_write  = ((opcode & OP_RW_MASK) == OP_MEM_WRITE_LO);
   wire       is_mem_read   = ((opcode & OP_RW_MASK) == OP_MEM_READ_LO);
   wire       is_status_wr  = (opcode == OP_STATUS_WRITE);
   wire       is_status_rd  = (opcode == OP_STATUS_READ);
   wire [7:0] status_image  = {4'h0, bp_snap[1], bp_snap[0], wel_snap, 1'b0};
   wire [ADDR_W-1:0] next_addr = addr + 1'b1;

   // byte framing; reset by cs high, so no link edge is needed after a frame
   always_ff @(posedge sck or posedge cs_b) begin
      if (cs_b) begin
         bit_cnt  <= 3'd0;
         shift_in <= 8'h00;
         state    <= ST_OPCODE;
      end else begin
         bit_cnt  <= bit_cnt + 3'd1;
         shift_in <= byte_in;
         if (byte_done) begin
            case (state)
               ST_OPCODE: begin
                  if (op_masked == OP_MEM_WRITE_LO || op_masked == OP_MEM_READ_LO) begin
                     state <= ST_ADDR;
                  end else if (byte_in == OP_STATUS_WRITE || byte_in == OP_STATUS_READ) begin
                     state <= ST_DATA;
                  end else begin
                     state <= ST_IGNORE;
                  end
               end
               ST_ADDR:   state <= ST_DATA;
               ST_DATA:   state <= ST_DATA;
               default:   state <= ST_IGNORE;
            endcase
         end
      end
   end

   // opcode, address, snapshots and array writes
   always_ff @(posedge sck) begin
      if (!cs_b && byte_done) begin
         case (state)
            ST_OPCODE: begin
               opcode     <= byte_in;
               addr[ADDR_W-1] <= byte_in[OP_ADDR_MSB_POS];
               wel_snap   <= wel_link;
               bp_snap    <= bp_link;
               wrote_any  <= 1'b0;
               sr_written <= 1'b0;
            end
            ST_ADDR: addr[ADDR_W-2:0] <= byte_in;
            ST_DATA: begin
               if (is_mem_write && wel_snap) begin
                  mem[addr] <= byte_in;
                  addr      <= next_addr;
                  wrote_any <= 1'b1;
               end else if (is_mem_read) begin
                  addr <= next_addr;
               end else if (is_status_wr && wel_snap && !sr_written) begin
                  sr_bp_new  <= {byte_in[SR_BP_HI_POS], byte_in[SR_BP_LO_POS]};
                  sr_written <= 1'b1;
               end
            end
            default: opcode <= opcode;
         endcase
      end
   end

   // output byte loaded on the falling edge that follows a byte boundary
   always_ff @(negedge sck or posedge cs_b) begin
      if (cs_b) begin
         out_shift <= 8'h00;
         so_oe     <= 1'b0;
      end else if (bit_cnt == 3'd0 && state == ST_DATA && (is_mem_read || is_status_rd)) begin
         out_shift <= is_status_rd ? status_image : mem[addr];
         so_oe     <= 1'b1;
      end else begin
         out_shift <= {out_shift[6:0], 1'b0};
      end
   end
   assign so = out_shift[7];

   // ----------------------------------------
   // link to system: events raised at frame end
   // ----------------------------------------
   // one toggle per event kind, so skew between bits cannot split an event
   always_ff @(posedge cs_b or negedge rst_b) begin
      if (!rst_b) begin
         sr_tog  <= 1'b0;
         set_tog <= 1'b0;
         clr_tog <= 1'b0;
         wr_tog  <= 1'b0;
      end else begin
         if (sr_written) begin
            sr_tog <= ~sr_tog;
         end
         if (opcode == OP_SET_WRITE_ENABLE) begin
            set_tog <= ~set_tog;
         end
         // the upper half write opcode does not clear the latch
         if (opcode == OP_CLEAR_WRITE_ENABLE || sr_written ||
             (wrote_any && opcode == OP_MEM_WRITE_LO)) begin
            clr_tog <= ~clr_tog;
         end
         if (wrote_any) begin
            wr_tog <= ~wr_tog;
         end
      end
   end

   // ----------------------------------------
   // system domain: status register
   // ----------------------------------------
   logic [3:0] tog_sync;
   logic [3:0] tog_seen;
   logic [1:0] bp_sync;
   logic [ADDR_W-1:0] addr_sync;

   level_sync #(.WIDTH(4)) u_tog_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({wr_tog, clr_tog, set_tog, sr_tog}),
      .q     (tog_sync)
   );
   // bp and address words are stable once cs is high and the frame toggle lands
   level_sync #(.WIDTH(2 + ADDR_W)) u_word_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({sr_bp_new, addr}),
      .q     ({bp_sync, addr_sync})
   );

   wire sr_evt    = tog_sync[0] ^ tog_seen[0];
   wire set_evt   = tog_sync[1] ^ tog_seen[1];
   wire clr_evt   = tog_sync[2] ^ tog_seen[2];
   wire wr_evt    = tog_sync[3] ^ tog_seen[3];
   wire next_wel  = set_evt ? 1'b1 : (clr_evt ? 1'b0 : write_enable_latch);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tog_seen           <= 4'h0;
         write_enable_latch <= SR_RESET[SR_WEL_POS];
         block_protect_lo   <= SR_RESET[SR_BP_LO_POS];
         block_protect_hi   <= SR_RESET[SR_BP_HI_POS];
         last_write_addr    <= '0;
      end else begin
         tog_seen           <= tog_sync;
         write_enable_latch <= next_wel;
         if (sr_evt) begin
            {block_protect_hi, block_protect_lo} <= bp_sync;
         end
         if (wr_evt) begin
            last_write_addr <= addr_sync;
         end
      end
   end

   // system state back into the link domain; stable while cs is low
   level_sync #(.WIDTH(3)) u_back_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({block_protect_hi, block_protect_lo, write_enable_latch}),
      .q     ({bp_link, wel_link})
   );
endmodule
`default_nettype wire

// >>> logic/wel_decode_pkg.sv
package wel_decode_pkg;
   // ----------------------------------------
   // opcodes
   // ----------------------------------------
   localparam logic [7:0] OP_SET_WRITE_ENABLE   = 8'h06;
   localparam logic [7:0] OP_CLEAR_WRITE_ENABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_READ        = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE       = 8'h01;
   localparam logic [7:0] OP_MEM_WRITE_LO       = 8'h02;
   localparam logic [7:0] OP_MEM_WRITE_HI       = 8'h0A;
   localparam logic [7:0] OP_MEM_READ_LO        = 8'h03;
   localparam logic [7:0] OP_MEM_READ_HI        = 8'h0B;
   localparam logic [7:0] OP_RW_MASK            = 8'hF7;
   localparam int         OP_ADDR_MSB_POS       = 3;
   // ----------------------------------------
   // status register layout
   // ----------------------------------------
   localparam int         SR_WEL_POS   = 1;
   localparam int         SR_BP_LO_POS = 2;
   localparam int         SR_BP_HI_POS = 3;
   localparam logic [7:0] SR_RESET     = 8'h00;
   // ----------------------------------------
   // array geometry
   // ----------------------------------------
   localparam int         ARRAY_ADDR_W = 9;
   localparam int         ARRAY_DEPTH  = 512;
   typedef enum logic [1:0] {ST_OPCODE, ST_ADDR, ST_DATA, ST_IGNORE} link_state_t;
endpackage

// >>> logic/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // level in and out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end
endmodule
`default_nettype wire

// >>> verif/wel_decode_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module wel_decode_assertions
   import wel_decode_pkg::*;
#(
   parameter int ADDR_W = ARRAY_ADDR_W
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              rst_b,
   // link
   input wire logic              sck,
   input wire logic              cs_b,
   input wire logic              si,
   input wire logic              so,
   input wire logic              so_oe,
   // status
   input wire logic              write_enable_latch,
   input wire logic              block_protect_lo,
   input wire logic              block_protect_hi,
   input wire logic [ADDR_W-1:0] last_write_addr
);
   wire logic [1:0] bp = {block_protect_hi, block_protect_lo};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_wel_reset_zero: assert property ($rose(rst_b) |-> !write_enable_latch)
      else $error("latch set after reset");
   a_wel_frame_end: assert property ($changed(write_enable_latch) |-> cs_b)
      else $error("latch moved inside frame");
   a_wel_settles: assert property ($rose(cs_b) |-> ##5 $stable(write_enable_latch) [*4])
      else $error("latch late after frame");
   a_so_idle_off: assert property (cs_b [*3] |-> !so_oe)
      else $error("so driven while idle");
   a_bp_frame_end: assert property ($changed(bp) |-> cs_b)
      else $error("protect moved inside frame");
   a_bp_needs_wel: assert property ($changed(bp) |-> $past(write_enable_latch, 2))
      else $error("protect written while locked");
   a_addr_frame_end: assert property ($changed(last_write_addr) |-> cs_b)
      else $error("address moved inside frame");
   a_addr_needs_wel: assert property ($changed(last_write_addr)
      |-> $past(write_enable_latch, 2))
      else $error("array written while locked");
   c_wel_set: cover property ($rose(write_enable_latch));
   c_wel_clear: cover property ($fell(write_enable_latch));
   c_hi_write: cover property ($changed(last_write_addr) && last_write_addr[8]);
endmodule
bind serial_fram_write_enable_decode wel_decode_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .clk(clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe),
   .write_enable_latch(write_enable_latch), .block_protect_lo(block_protect_lo),
   .block_protect_hi(block_protect_hi), .last_write_addr(last_write_addr));
`default_nettype wire

// >>> verif/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // link
   output logic     sck,
   output logic     cs_b,
   output logic     si,
   input wire logic so,
   input wire logic so_oe
);
   initial begin
      sck = 1'b0;
      cs_b = 1'b1;
      si = 1'b0;
   end
   // n bytes from the low end of d, msb first; sck stands low between frames
   task automatic frame(input int n, input logic [23:0] d, output logic [7:0] r);
      #7;
      cs_b = 1'b0;
      #24;
      for (int i = n * 8 - 1; i >= 0; i--) begin
         si = d[i];
         #24;
         sck = 1'b1;
         r = {r[6:0], so & so_oe};
         #24;
         sck = 1'b0;
      end
      #24;
      cs_b = 1'b1;
      si = ~si;
   endtask
endmodule
`default_nettype wire

// >>> verif/serial_fram_write_enable_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
module serial_fram_write_enable_decode_test
   import wel_decode_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   wire logic  sck, cs_b, si, so, so_oe, wel, bp_lo, bp_hi;
   wire logic  [8:0] addr;
   logic [7:0] r;
   int         err_count = 0;
   int         n_compared = 0;
   int         cycles = 0;
   always #5 clk = ~clk;
   serial_fram_write_enable_decode u_serial_fram_write_enable_decode (.clk(clk),
      .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe),
      .write_enable_latch(wel), .block_protect_lo(bp_lo), .block_protect_hi(bp_hi),
      .last_write_addr(addr));
   spi_host_model u_spi_host_model (.sck(sck), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe));
   task automatic check(input logic [8:0] e, input logic [8:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic f(input int n, input logic [23:0] d);
      u_spi_host_model.frame(n, d, r);
      repeat (10) @(negedge clk);
   endtask
   task automatic t_reset;
      f(2, {8'h00, OP_STATUS_READ, 8'h00});
      check(9'h000, 9'(r));
      check(9'h000, 9'(wel));
      $display("t_reset done");
   endtask
   task automatic t_latch;
      f(1, {16'h0000, OP_SET_WRITE_ENABLE});
      f(2, {8'h00, OP_STATUS_READ, 8'h00});
      check(9'h002, 9'(r));
      f(3, {OP_MEM_READ_HI, 8'h56, 8'h00});
      check(9'h001, 9'(wel));
      f(1, {16'h0000, OP_CLEAR_WRITE_ENABLE});
      check(9'h000, 9'(wel));
      f(3, {OP_MEM_WRITE_LO, 8'h12, 8'h5A});
      check(9'h000, addr);
      f(2, {8'h00, OP_STATUS_WRITE, 8'hFF});
      check(9'h000, 9'({bp_hi, bp_lo}));
      $display("t_latch done");
   endtask
   task automatic t_status;
      f(1, {16'h0000, OP_SET_WRITE_ENABLE});
      f(2, {8'h00, OP_STATUS_WRITE, 8'hFF});
      f(2, {8'h00, OP_STATUS_READ, 8'h00});
      check(9'h00C, 9'(r));
      check(9'h003, 9'({bp_hi, bp_lo}));
      f(1, {16'h0000, OP_SET_WRITE_ENABLE});
      f(2, {8'h00, OP_STATUS_WRITE, 8'h00});
      check(9'h000, 9'({bp_hi, bp_lo, wel}));
      $display("t_status done");
   endtask
   task automatic t_write;
      f(1, {16'h0000, OP_SET_WRITE_ENABLE});
      f(3, {OP_MEM_WRITE_LO, 8'h34, 8'h5A});
      check(9'h01A, 9'(addr[8:1]));
      check(9'h000, 9'(wel));
      f(1, {16'h0000, OP_SET_WRITE_ENABLE});
      f(3, {OP_MEM_WRITE_HI, 8'h56, 8'hA5});
      check(9'h0AB, 9'(addr[8:1]));
      check(9'h001, 9'(wel));
      f(3, {OP_MEM_WRITE_LO, 8'h78, 8'h3C});
      check(9'h03C, 9'(addr[8:1]));
      f(1, {16'h0000, OP_SET_WRITE_ENABLE});
      f(3, {OP_MEM_WRITE_HI, 8'h10, 8'h00});
      f(1, {16'h0000, OP_CLEAR_WRITE_ENABLE});
      check(9'h000, 9'(wel));
      $display("t_write done");
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      t_reset;
      t_latch;
      t_status;
      t_write;
      tally_and_finish;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish;
      end
   end
endmodule
`default_nettype wire
